/* File: hdl/fsr_retransmit_fifo.sv */
// port-A to port-B queue with synchronous retransmit and fill flags
// assumes writer, reader and retransmit control all run on clk
// (clk is the port-B clock); offsets are static configuration
`timescale 1ns/1ns
// Notes on behaviour
// - queue holds 512 words of 32 bits, written on A, read on B
// - enter retransmit when mode input high and output-ready high
// - word in output register at entry is the loop's first word
// - stay in retransmit until an edge samples the mode input low
// - rewind edge puts marked word in output register; reads go on
// - rewind loads current read pointer with shadow pointer plus one
// - every rewind pulse in retransmit starts another loop, except on the exit edge
// - current pointer steps per new output word; drives ready/empty
// - shadow pointer caught at entry, held; reference for full flags
// - writes continue in retransmit without overwriting loop data
// - almost-full low when fill from mark reaches depth minus offset
// - input-ready low once the queue from the mark is full
// - output-ready follows the restored level at once
// - almost-empty may lag a rewind by up to two edges
// - exit edge moves full-flag reference back to current pointer
// - controller may exit any time; plain FIFO order resumes
module fsr_retransmit_fifo #(
  parameter int WIDTH = fsr_pkg::WIDTH,
  parameter int DEPTH = fsr_pkg::DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     writeValid,
  input  wire logic [WIDTH-1:0]         writeData,
  output logic                          writeReady,
  input  wire logic                     readEn,
  output logic      [WIDTH-1:0]         readData,
  input  wire logic                     retransmitModeIn,
  input  wire logic                     readFromMarkIn,
  input  wire logic [fsr_pkg::PTR_W-1:0] almostFullOffset,
  input  wire logic [fsr_pkg::PTR_W-1:0] almostEmptyOffset,
  output logic                          portBOutputReady,
  output logic                          portBAlmostEmptyN,
  output logic                          portAInputReady,
  output logic                          portAAlmostFullN,
  output logic                          retransmitActive
);
  localparam int PW = fsr_pkg::PTR_W;
  localparam int AW = fsr_pkg::ADDR_W;
  localparam logic [PW-1:0] FULL = PW'(DEPTH);
  localparam logic [PW-1:0] ONE  = PW'(1);
  localparam logic [PW-1:0] PTR_ZERO = fsr_pkg::PTR_RESET;

  function automatic logic [PW-1:0] level(input logic [PW-1:0] head,
                                          input logic [PW-1:0] tail);
    level = PW'(head - tail);
  endfunction : level

  logic [WIDTH-1:0]    mem [DEPTH];
  logic [PW-1:0]       wrPtr_reg;
  logic [PW-1:0]       wrPtr_next;
  logic [PW-1:0]       rdPtr_reg;
  logic [PW-1:0]       rdPtr_next;
  logic [PW-1:0]       shadowPtr_reg;
  logic [PW-1:0]       shadowPtr_next;
  fsr_pkg::fsr_mode_t  mode_reg;
  fsr_pkg::fsr_mode_t  mode_next;
  logic [WIDTH-1:0]    outData_reg;
  logic [WIDTH-1:0]    outData_next;
  logic                orb_reg;
  logic                orb_next;
  logic                aeN_reg;
  logic                afN_reg;
  logic                ira_reg;
  logic                bufValid;
  logic [WIDTH-1:0]    bufData;

  // writer side: the buffer absorbs a stall while the queue is full
  fsr_two_entry_buffer #(
    .WIDTH (WIDTH)
  ) u_inBuf (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (writeValid),
    .inData   (writeData),
    .inReady  (writeReady),
    .outValid (bufValid),
    .outData  (bufData),
    .outReady (ira_reg)
  );

  wire inRetransmit = (mode_reg == fsr_pkg::FSR_MODE_RETRANSMIT);
  wire enterMode = !inRetransmit && retransmitModeIn && orb_reg;
  wire exitMode  = inRetransmit && !retransmitModeIn;
  // a held rewind input restarts the loop every edge
  wire rewind    = inRetransmit && retransmitModeIn
                   && readFromMarkIn;
  wire memWrite  = bufValid && ira_reg;
  wire readTake  = readEn && orb_reg;
  wire [PW-1:0] fillCur = level(wrPtr_reg, rdPtr_reg);
  wire fetch     = !rewind && (!orb_reg || readTake)
                   && (fillCur != PTR_ZERO);

  assign wrPtr_next = PW'(wrPtr_reg + {{(PW-1){1'b0}}, memWrite});
  assign rdPtr_next = rewind ? PW'(shadowPtr_reg + ONE)
                    : fetch  ? PW'(rdPtr_reg + ONE)
                    : rdPtr_reg;
  // mark sits one behind the next-fetch pointer
  assign shadowPtr_next = enterMode ? PW'(rdPtr_reg - ONE)
                                    : shadowPtr_reg;
  assign mode_next = enterMode ? fsr_pkg::FSR_MODE_RETRANSMIT
                   : exitMode  ? fsr_pkg::FSR_MODE_NORMAL
                   : mode_reg;
  assign orb_next  = rewind || fetch || (orb_reg && !readTake);
  assign outData_next = rewind ? mem[shadowPtr_reg[AW-1:0]]
                      : fetch  ? mem[rdPtr_reg[AW-1:0]]
                      : outData_reg;

  // full-side reference; normal mode keeps the output word's slot
  // reserved so entering retransmit never finds it overwritten
  wire [PW-1:0] refNext = (mode_next == fsr_pkg::FSR_MODE_RETRANSMIT)
                          ? shadowPtr_next
                          : PW'(rdPtr_next - {{(PW-1){1'b0}}, orb_next});
  wire [PW-1:0] refNow  = inRetransmit ? shadowPtr_reg
                          : PW'(rdPtr_reg - {{(PW-1){1'b0}}, orb_reg});
  wire [PW-1:0] fillRefNext = level(wrPtr_next, refNext);
  wire [PW-1:0] fillRef     = level(wrPtr_reg, refNow);
  wire [PW-1:0] fillOutNext = PW'(level(wrPtr_next, rdPtr_next)
                              + {{(PW-1){1'b0}}, orb_next});
  wire [PW-1:0] afLimit     = PW'(FULL - almostFullOffset);
  wire iraNext = (fillRefNext < FULL);
  wire afNNext = (fillRefNext < afLimit);
  wire aeNNext = (fillOutNext > almostEmptyOffset);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg     <= fsr_pkg::PTR_RESET;
      rdPtr_reg     <= fsr_pkg::PTR_RESET;
      shadowPtr_reg <= fsr_pkg::PTR_RESET;
      mode_reg      <= fsr_pkg::FSR_MODE_NORMAL;
      outData_reg   <= fsr_pkg::DATA_RESET;
      orb_reg       <= 1'b0;
      aeN_reg       <= 1'b0;
      afN_reg       <= 1'b1;
      ira_reg       <= 1'b1;
    end else begin
      wrPtr_reg     <= wrPtr_next;
      rdPtr_reg     <= rdPtr_next;
      shadowPtr_reg <= shadowPtr_next;
      mode_reg      <= mode_next;
      outData_reg   <= outData_next;
      orb_reg       <= orb_next;
      aeN_reg       <= aeNNext;
      afN_reg       <= afNNext;
      ira_reg       <= iraNext;
    end
  end

  // storage has no reset; contents are only read once written
  always_ff @(posedge clk) begin
    if (memWrite) begin
      mem[wrPtr_reg[AW-1:0]] <= bufData;
    end
  end

  assign readData          = outData_reg;
  assign portBOutputReady  = orb_reg;
  assign portBAlmostEmptyN = aeN_reg;
  assign portAInputReady   = ira_reg;
  assign portAAlmostFullN  = afN_reg;
  assign retransmitActive  = inRetransmit;

  // checking helpers
  logic [WIDTH-1:0] markData_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      markData_reg <= fsr_pkg::DATA_RESET;
    end else if (enterMode) begin
      markData_reg <= outData_reg;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_enter;
    !inRetransmit && retransmitModeIn && orb_reg;
  endsequence
  sequence s_loop;
    inRetransmit && retransmitModeIn && readFromMarkIn;
  endsequence

  a_enter_mode: assert property (s_enter |=> retransmitActive)
    else $error("retransmit not entered");
  a_mark_pointer: assert property (
    s_enter |=> shadowPtr_reg == PW'($past(rdPtr_reg) - ONE))
    else $error("mark pointer wrong");
  a_stay_mode: assert property (
    inRetransmit && retransmitModeIn |=> retransmitActive)
    else $error("left retransmit early");
  a_loop_word: assert property (
    s_loop |=> portBOutputReady && readData == markData_reg)
    else $error("rewind word differs from mark");
  a_loop_pointer: assert property (
    s_loop |=> rdPtr_reg == PW'(shadowPtr_reg + ONE))
    else $error("current pointer not reloaded");
  a_loop_repeat: assert property (
    s_loop ##1 s_loop |=> readData == markData_reg)
    else $error("second loop failed");
  a_fetch_step: assert property (
    fetch |=> rdPtr_reg == PW'($past(rdPtr_reg) + ONE) && orb_reg)
    else $error("read pointer did not step");
  a_shadow_hold: assert property (
    inRetransmit && !exitMode |=> $stable(shadowPtr_reg))
    else $error("shadow pointer moved");
  a_no_overwrite: assert property (
    memWrite |-> fillRef < FULL)
    else $error("write into protected data");
  a_almost_full: assert property (
    portAAlmostFullN == (fillRef < PW'(FULL - almostFullOffset)))
    else $error("almost-full flag wrong");
  a_input_ready: assert property (
    portAInputReady == (fillRef != FULL))
    else $error("input-ready flag wrong");
  a_ready_now: assert property (
    s_loop |=> portBOutputReady)
    else $error("output-ready late after rewind");
  a_empty_lag: assert property (
    s_loop |-> ##[1:2] (portBAlmostEmptyN ==
      (PW'(fillCur + {{(PW-1){1'b0}}, orb_reg}) > almostEmptyOffset)))
    else $error("almost-empty did not settle");
  a_exit_ref: assert property (
    exitMode |=> !retransmitActive
      && fillRef == level(wrPtr_reg, PW'(rdPtr_reg - orb_reg)))
    else $error("reference not switched on exit");

  // refusal paths, pointer bookkeeping and stall safety
  sequence s_exit;
    inRetransmit && !retransmitModeIn;
  endsequence
  sequence s_exit_mark;
    inRetransmit && !retransmitModeIn && readFromMarkIn && orb_reg && !readEn;
  endsequence
  sequence s_idle_mark;
    !inRetransmit && readFromMarkIn && orb_reg && !readEn;
  endsequence
  sequence s_take_last;
    readTake && !rewind && fillCur == PTR_ZERO;
  endsequence

  a_entry_refused: assert property (
    !inRetransmit && !(retransmitModeIn && orb_reg) |=> !retransmitActive)
    else $error("retransmit entered without request");
  a_mark_word: assert property (
    s_enter |=> markData_reg == $past(readData))
    else $error("marked word not captured");
  a_exit_mode: assert property (
    s_exit |=> !retransmitActive)
    else $error("retransmit not left");
  a_loop_shadow: assert property (
    s_loop |=> $stable(shadowPtr_reg))
    else $error("rewind disturbed the shadow pointer");
  a_idle_rewind: assert property (
    s_idle_mark |=> $stable(rdPtr_reg) && $stable(readData))
    else $error("rewind acted outside retransmit");
  a_take_empty: assert property (
    s_take_last |=> !portBOutputReady)
    else $error("output-ready stuck after last word");
  a_fetch_fill: assert property (
    !orb_reg && !rewind && fillCur != PTR_ZERO |=> portBOutputReady)
    else $error("stored word not fetched");
  a_read_hold: assert property (
    orb_reg && !readEn && !rewind |=> portBOutputReady && $stable(readData))
    else $error("output word changed without a take");
  a_ptr_hold: assert property (
    !fetch && !rewind |=> $stable(rdPtr_reg))
    else $error("read pointer moved without a fetch");
  a_empty_zero: assert property (
    !orb_reg && fillCur == PTR_ZERO |-> !portBAlmostEmptyN)
    else $error("almost-empty high with nothing held");
  a_shadow_idle: assert property (
    !inRetransmit && !enterMode |=> $stable(shadowPtr_reg))
    else $error("shadow pointer moved outside entry");
  a_mark_kept: assert property (
    inRetransmit |-> mem[shadowPtr_reg[AW-1:0]] == markData_reg)
    else $error("marked word overwritten");
  a_write_step: assert property (
    memWrite |=> wrPtr_reg == PW'($past(wrPtr_reg) + ONE))
    else $error("write pointer did not step");
  a_write_hold: assert property (
    !memWrite |=> $stable(wrPtr_reg))
    else $error("write pointer moved without a write");
  a_stall_hold: assert property (
    bufValid && !ira_reg |=> bufValid && $stable(bufData))
    else $error("stalled word lost");
  a_buffer_space: assert property (
    !bufValid |-> writeReady)
    else $error("empty buffer refuses a word");
  a_full_blocks: assert property (
    !portAInputReady |-> !memWrite)
    else $error("write while input-ready low");
  a_fill_bound: assert property (
    fillRef <= FULL)
    else $error("fill beyond depth");
  a_exit_wins: assert property (
    s_exit_mark |=> $stable(rdPtr_reg) && $stable(readData))
    else $error("rewind acted on the exit edge");
endmodule : fsr_retransmit_fifo

/* File: hdl/fsr_pkg.sv */
// shared constants and types for the retransmit queue
// assumes one clock domain; consumers write fsr_pkg::name, no import
package fsr_pkg;
  localparam int          DEPTH       = 512;
  localparam int          WIDTH       = 32;
  localparam int          ADDR_W      = 9;
  localparam int          PTR_W       = 10;
  localparam int          BUF_ENTRIES = 2;
  localparam logic [9:0]  PTR_RESET   = 10'h000;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
  localparam logic [1:0]  SEL_RESET   = 2'h0;

  typedef enum logic {
    FSR_MODE_NORMAL,
    FSR_MODE_RETRANSMIT
  } fsr_mode_t;
endpackage : fsr_pkg

/* File: hdl/fsr_two_entry_buffer.sv */
// two-entry buffer with valid/ready on both sides
// assumes clk/resetn shared with the queue that drains it
`timescale 1ns/1ns
module fsr_two_entry_buffer #(
  parameter int WIDTH = fsr_pkg::WIDTH
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] slot [fsr_pkg::BUF_ENTRIES];
  logic             wrSel_reg;
  logic             rdSel_reg;
  logic [1:0]       count_reg;
  logic [1:0]       count_next;
  logic             inReady_reg;
  wire              push = inValid && inReady_reg;
  wire              pop  = outValid && outReady;

  assign count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});
  assign outValid   = (count_reg != fsr_pkg::SEL_RESET);
  assign outData    = slot[rdSel_reg];
  assign inReady    = inReady_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrSel_reg   <= 1'b0;
      rdSel_reg   <= 1'b0;
      count_reg   <= fsr_pkg::SEL_RESET;
      inReady_reg <= 1'b1;
    end else begin
      wrSel_reg   <= wrSel_reg ^ push;
      rdSel_reg   <= rdSel_reg ^ pop;
      count_reg   <= count_next;
      // registered ready: full stalls the writer on the next edge
      inReady_reg <= (count_next != 2'(fsr_pkg::BUF_ENTRIES));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      slot[wrSel_reg] <= inData;
    end
  end
endmodule : fsr_two_entry_buffer

/* File: verification/fsr_writer_model.sv */
// port-A writer model: offers one word at a time on valid/ready
// assumes the bench clock; drives 1 ns after the rising edge
`timescale 1ns/1ns
module fsr_writer_model (
  input  wire logic        clk,
  input  wire logic        writeReady,
  output logic             writeValid,
  output logic [31:0]      writeData
);
  initial begin
    writeValid = 1'h0;
    writeData  = 32'h0000_0000;
  end
  task automatic send(input logic [31:0] d, input int stall,
                      output bit ok);
    int n;
    ok = 1'h0;
    repeat (stall + 1) @(posedge clk);
    #1;
    writeValid = 1'h1;
    writeData  = d;
    for (n = 0; n < 64 && !ok; n++) begin
      ok = (writeReady === 1'h1);
      @(posedge clk);
      #1;
    end
    writeValid = 1'h0;
    writeData  = ~d;  // idle bus must not look like the last word
  endtask : send
endmodule : fsr_writer_model

/* File: verification/fsr_retransmit_fifo_bench.sv */
// self-checking bench for the retransmit queue
// assumes the writer model on port A; the bench is the port-B reader
`timescale 1ns/1ns
module fsr_retransmit_fifo_bench;
  logic                      clk, resetn, readEn, retransmitModeIn;
  logic                      readFromMarkIn, writeValid, writeReady;
  logic [31:0]               writeData, readData, base;
  logic [fsr_pkg::PTR_W-1:0] almostFullOffset, almostEmptyOffset;
  logic                      portBOutputReady, portBAlmostEmptyN;
  logic                      portAInputReady, portAAlmostFullN;
  logic                      retransmitActive;
  logic [31:0]               expq[$];
  int                        errCount, checksDone, k, afOff;

  fsr_writer_model i_writer (.clk(clk), .writeReady(writeReady),
    .writeValid(writeValid), .writeData(writeData));
  fsr_retransmit_fifo i_dut (.clk(clk), .resetn(resetn),
    .writeValid(writeValid), .writeData(writeData),
    .writeReady(writeReady), .readEn(readEn), .readData(readData),
    .retransmitModeIn(retransmitModeIn), .readFromMarkIn(readFromMarkIn),
    .almostFullOffset(almostFullOffset),
    .almostEmptyOffset(almostEmptyOffset),
    .portBOutputReady(portBOutputReady),
    .portBAlmostEmptyN(portBAlmostEmptyN),
    .portAInputReady(portAInputReady), .portAAlmostFullN(portAAlmostFullN),
    .retransmitActive(retransmitActive));

  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : completeRun
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic fail(input string what);
    errCount++;
    $display("MISMATCH %0t %s", $time, what);
    completeRun();
  endtask : fail
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic put(input logic [31:0] d);
    bit ok;
    i_writer.send(d, $urandom % 3, ok);
    if (!ok) fail("writer stuck");
  endtask : put
  task automatic waitReady();
    for (k = 0; k < 20 && portBOutputReady !== 1'h1; k++) step();
    if (portBOutputReady !== 1'h1) fail("no output word");
  endtask : waitReady
  // readEn only where output-ready is high, so each take is certain
  task automatic takeWords(input logic [31:0] first, input int count);
    int i, w;
    i = 0;
    for (w = 0; w < 4000 && i < count; w++) begin
      readEn = (portBOutputReady === 1'h1);
      if (readEn) expq.push_back(first + i);
      if (readEn) i++;
      step();
    end
    readEn = 1'h0;
    if (i < count || expq.size() != 0) fail("reads incomplete");
  endtask : takeWords
  task automatic rewind(input logic [31:0] mark);
    readFromMarkIn = 1'h1;  // one-cycle pulse per loop
    step();
    readFromMarkIn = 1'h0;
    check(32'(portBOutputReady), 32'h0000_0001, "ready at rewind");
    check(readData, mark, "rewound word");
    step();
    step();
    check(32'(portBAlmostEmptyN), 32'h0000_0001, "level");
  endtask : rewind

  always @(posedge clk) begin
    if (resetn === 1'h1 && readEn === 1'h1 && portBOutputReady === 1'h1) begin
      if (expq.size() == 0) fail("unexpected word");
      else check(readData, expq.pop_front(), "word order");
    end
  end

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    resetn = 1'h0;
    readEn = 1'h0;
    retransmitModeIn = 1'h0;
    readFromMarkIn = 1'h0;
    almostEmptyOffset = 10'h008;
    k = $urandom(32'h2033_eb0d);
    afOff = 4 + $urandom % 60;
    almostFullOffset = 10'(afOff);
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'h1;
    step();
    check(32'({writeReady, portBOutputReady, portBAlmostEmptyN,
      portAInputReady, portAAlmostFullN, retransmitActive}), 32'h0000_0026,
      "reset flags");
    retransmitModeIn = 1'h1;  // refused: nothing to mark yet
    step();
    retransmitModeIn = 1'h0;
    check(32'(retransmitActive), 32'h0000_0000, "empty entry");
    for (int i = 0; i < 6; i++) put(32'h1000_0000 + i);
    takeWords(32'h1000_0000, 6);
    $display("test plain order done");
    base = 32'h2000_0000;
    for (int i = 0; i < 10; i++) put(base + i);
    waitReady();
    retransmitModeIn = 1'h1;
    step();
    check(32'(retransmitActive), 32'h0000_0001, "entry");
    check(readData, base, "marked word");
    takeWords(base, 2);  // two reads from the mark first
    check(32'(portBAlmostEmptyN), 32'h0000_0000, "low level");
    for (int i = 0; i < 2; i++) begin
      rewind(base);
      takeWords(base, 3 + 2 * i);
    end
    retransmitModeIn = 1'h0;
    step();
    check(32'(retransmitActive), 32'h0000_0000, "exit");
    readFromMarkIn = 1'h1;  // rewind pulse outside retransmit is ignored
    step();
    readFromMarkIn = 1'h0;
    check(readData, base + 5, "rewind refused");
    takeWords(base + 5, 5);
    $display("test loops done");
    base = 32'h3000_0000;
    for (int i = 0; i < 3; i++) put(base + i);
    waitReady();
    retransmitModeIn = 1'h1;
    step();
    takeWords(base, 2);
    for (int i = 3; i <= 513; i++) begin
      put(base + i);
      step();
      step();
      if (i < 512) begin
        check(32'(portAInputReady), 32'(i < 511), "input ready");
        check(32'(portAAlmostFullN), 32'(i + 1 < 512 - afOff), "afull");
      end
    end
    check(32'(writeReady), 32'h0000_0000, "buffer refuses");
    retransmitModeIn = 1'h0;
    readFromMarkIn = 1'h1;  // exit wins over a rewind on the same edge
    step();
    readFromMarkIn = 1'h0;
    check(readData, base + 2, "no rewind on exit");
    for (k = 0; k < 8 && writeReady !== 1'h1; k++) step();
    check(32'(writeReady), 32'h0000_0001, "space after exit");
    takeWords(base + 2, 512);
    $display("test full flags done");
    completeRun();
  end
endmodule : fsr_retransmit_fifo_bench
